// File: core/spre_pkg.sv
// Package for the SPI request exception handler: response kinds, frame summary and response word.
// Assumes a frame decoder upstream that classifies each completed frame.
package spre_pkg;

    // Response kinds shifted out on the following frame
    typedef enum logic [3:0] {
        SPRE_RESP_SPI_ERR    = 4'h0,
        SPRE_RESP_MISO_ERR   = 4'h1,
        SPRE_RESP_INV_ACCEL  = 4'h2,
        SPRE_RESP_INV_REG    = 4'h3,
        SPRE_RESP_INT_ERR    = 4'h4,
        SPRE_RESP_ST_ERR     = 4'h5,
        SPRE_RESP_VALID_ACC  = 4'h6,
        SPRE_RESP_REG_READ   = 4'h7,
        SPRE_RESP_REG_WRITE  = 4'h8
    } spre_resp_kind_t;

    localparam logic [1:0] SPRE_STAT_NORMAL = 2'h0;
    localparam logic [1:0] SPRE_STAT_OVR = 2'h2;
    localparam int SPRE_AXES = 2;

    // Summary of one completed frame, made by the frame decoder
    typedef struct packed {
        logic spi_err;
        logic miso_err;
        logic is_accel;
        logic is_write;
        logic axis;
        logic cfg_mismatch;
        logic reg_writable;
        logic reg_readable;
        logic is_ctl_reg;
        logic is_stat_reg;
    } spre_frame_t;

    // Response selected for the next frame
    typedef struct packed {
        spre_resp_kind_t kind;
        logic [1:0] status;
    } spre_resp_t;

    localparam spre_frame_t SPRE_FRAME_RST = '0;
    localparam spre_resp_t SPRE_RESP_RST = '{kind: SPRE_RESP_SPI_ERR, status: SPRE_STAT_NORMAL};

endpackage : spre_pkg

// File: core/spre_exception_handler.sv
// Exception handling for the sensor's SPI slave: picks the next frame's response and keeps status flags.
// Assumes a frame decoder on link_clk_i that pulses frame_done_i with a frame summary after each frame,
// and that link_clk_i keeps running for at least eight edges after every frame.
//
// Overview of operation
// [RQ1] Accel request config mismatch: invalid-accel response next frame only, no fault stored
// [RQ2] Accel mismatch: no arming update, PCM untouched
// [RQ3] Write to unwritable register gives invalid-register-request response
// [RQ4] With config lock set, writes except to control register are invalid requests
// [RQ5] Read of unreadable register gives invalid-register-request response
// [RQ6] Init or reset flag set: accel requests get error response until both clear
// [RQ7] Init-in-progress flag clears itself when initialization ends
// [RQ8] Status register read clears the reset-occurred flag
// [RQ9] Init or reset flag set: no arming update, PCM disabled
// [RQ10] Internal error set by OTP CRC, register CRC, self-test or bad logic state
// [RQ11] CRC internal error: internal-error response, no arming, PCM untouched
// [RQ12] Register CRC error after lock clears only by reset, not status read
// [RQ13] OTP shadow CRC error is permanent
// [RQ14] Self-test internal error: self-test-error response, no arming, PCM untouched
// [RQ15] Self-test error stays until status read; still set if fault persists then
// [RQ16] Axis offset over range: valid response with status 10, arming continues
// [RQ17] After over range ends, one more status-10 response then normal
// [RQ18] Offset and modulator over-range flags sticky until status read
// [RQ19] Modulator over range: valid response with status 10, arming and PCM continue
// [RQ20] First response after any reset is the SPI-error response
// [RQ21] After reset accel requests get invalid-accel response until status read
// [RQ22] Register reads and writes still execute during data exceptions
// [RQ23] Coexisting exceptions resolved by fixed priority, SPI error highest
// [RQ24] Host keeps clock low at select edges and sends 16 clocks per frame
// [RQ25] Exceptions evaluated at frame end; response registered for the next frame
`timescale 1ns/100ps

module spre_exception_handler (
    // Core clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Link clock, reset and frame summary
    input wire logic link_clk_i,
    input wire logic link_resetn_i,
    input wire logic frame_done_i,
    input wire spre_pkg::spre_frame_t frame_i,
    // Response for the next frame, link domain
    output spre_pkg::spre_resp_t next_resp_o,
    // Configuration and fault sources, core domain
    input wire logic config_lock_flag_i,
    input wire logic init_done_i,
    input wire logic otp_crc_err_i,
    input wire logic wreg_crc_err_i,
    input wire logic self_test_err_i,
    input wire logic logic_state_err_i,
    input wire logic [1:0] offset_ovr_i,
    input wire logic modulator_ovr_i,
    // Status flags
    output logic init_in_progress_flag_o,
    output logic reset_occurred_flag_o,
    output logic internal_error_flag_o,
    output logic [1:0] offset_ovr_flag_o,
    output logic modulator_overrange_flag_o,
    // Effects on the rest of the device
    output logic arm_update_o,
    output logic pcm_enable_o,
    output logic reg_write_en_o,
    output logic reg_read_en_o,
    output logic status_read_o
);
    import spre_pkg::*;

    // Link side: hold frame summary, flag it by toggle
    spre_frame_t frame_hold_q;
    logic frame_tgl_q;
    logic rt_s1_q;
    logic rt_s2_q;
    logic rt_s3_q;
    spre_resp_t next_resp_q;

    // Written on the core side, read here only after the toggle has crossed
    spre_resp_t resp_hold_q;
    logic resp_tgl_q;

    // Summary is held untouched until the next frame, so the core may read it late
    always_ff @(posedge link_clk_i) begin
        if (!link_resetn_i) begin
            frame_hold_q <= SPRE_FRAME_RST;
        end else if (frame_done_i) begin
            frame_hold_q <= frame_i;
        end
    end

    // A toggle rather than a pulse survives the slower core clock
    always_ff @(posedge link_clk_i) begin
        if (!link_resetn_i) begin
            frame_tgl_q <= 1'b0;
        end else if (frame_done_i) begin
            frame_tgl_q <= ~frame_tgl_q;
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!link_resetn_i) begin
            rt_s1_q <= 1'b0;
            rt_s2_q <= 1'b0;
            rt_s3_q <= 1'b0;
        end else begin
            rt_s1_q <= resp_tgl_q;
            rt_s2_q <= rt_s1_q;
            rt_s3_q <= rt_s2_q;
        end
    end

    // Reset value makes the first shifted response an SPI error
    always_ff @(posedge link_clk_i) begin
        if (!link_resetn_i) begin
            next_resp_q <= SPRE_RESP_RST; // [RQ20]
        end else if (rt_s2_q ^ rt_s3_q) begin
            next_resp_q <= resp_hold_q; // [RQ25]
        end
    end

    assign next_resp_o = next_resp_q;

    // Core side: frame event crossing
    logic ft_s1_q;
    logic ft_s2_q;
    logic ft_s3_q;
    logic new_frame;
    spre_frame_t fr;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ft_s1_q <= 1'b0;
            ft_s2_q <= 1'b0;
            ft_s3_q <= 1'b0;
        end else begin
            ft_s1_q <= frame_tgl_q;
            ft_s2_q <= ft_s1_q;
            ft_s3_q <= ft_s2_q;
        end
    end

    // Hold register is stable once the toggle has passed two flops
    assign new_frame = ft_s2_q ^ ft_s3_q;
    assign fr = frame_hold_q;

    // Request classification
    logic link_err;
    logic reg_invalid;
    logic accel_mismatch;
    logic reg_ok;
    logic stat_read;

    always_comb begin
        link_err = fr.spi_err | fr.miso_err; // [RQ24]
        accel_mismatch = fr.is_accel & fr.cfg_mismatch; // [RQ1]
        reg_invalid = 1'b0;
        if (!fr.is_accel) begin
            if (fr.is_write) begin
                reg_invalid = ~fr.reg_writable; // [RQ3]
                if (config_lock_flag_i && !fr.is_ctl_reg) begin
                    reg_invalid = 1'b1; // [RQ4]
                end
            end else begin
                reg_invalid = ~fr.reg_readable; // [RQ5]
            end
        end
        reg_ok = new_frame & ~fr.is_accel & ~fr.spi_err & ~reg_invalid; // [RQ22]
        // A read under an output mismatch is dropped and clears nothing
        stat_read = reg_ok & ~fr.is_write & ~link_err & fr.is_stat_reg; // [RQ8]
    end

    // Device status flags
    logic init_q;
    logic resoc_q;
    logic otp_crc_q;
    logic wcrc_q;
    logic wcrc_locked_q;
    logic st_q;
    logic lgc_q;
    logic [1:0] ofs_q;
    logic [1:0] ofs_tail_q;
    logic sd_q;
    logic sd_tail_q;
    logic crc_err;
    logic int_err;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            init_q <= 1'b1;
        end else if (init_done_i) begin
            init_q <= 1'b0; // [RQ7]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            resoc_q <= 1'b1;
        end else if (stat_read) begin
            resoc_q <= 1'b0; // [RQ8]
        end
    end

    // OTP shadow CRC fault clears only on reset, never by a status read
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            otp_crc_q <= 1'b0;
        end else if (otp_crc_err_i) begin
            otp_crc_q <= 1'b1; // [RQ13]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            wcrc_q <= 1'b0;
            wcrc_locked_q <= 1'b0;
        end else if (wreg_crc_err_i) begin
            wcrc_q <= 1'b1; // [RQ10]
            wcrc_locked_q <= wcrc_locked_q | config_lock_flag_i;
        end else if (stat_read && !wcrc_locked_q) begin
            wcrc_q <= 1'b0; // [RQ12]
        end
    end

    // Set wins over the read clear, so a lasting fault keeps the flag
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            st_q <= 1'b0;
        end else if (self_test_err_i) begin
            st_q <= 1'b1; // [RQ15]
        end else if (stat_read) begin
            st_q <= 1'b0; // [RQ15]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            lgc_q <= 1'b0;
        end else if (logic_state_err_i) begin
            lgc_q <= 1'b1; // [RQ10]
        end else if (stat_read) begin
            lgc_q <= 1'b0;
        end
    end

    // A fault still present at the read keeps its flag set
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ofs_q <= '0;
        end else begin
            ofs_q <= offset_ovr_i | (ofs_q & {SPRE_AXES{~stat_read}}); // [RQ18]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            sd_q <= 1'b0;
        end else begin
            sd_q <= modulator_ovr_i | (sd_q & ~stat_read); // [RQ18]
        end
    end

    assign crc_err = otp_crc_q | wcrc_q;
    assign int_err = crc_err | st_q | lgc_q; // [RQ10]

    // Response selection by fixed priority
    spre_resp_t resp_d;
    logic arm_d;
    logic acc_ok;

    always_comb begin
        resp_d = '{kind: SPRE_RESP_VALID_ACC, status: SPRE_STAT_NORMAL};
        arm_d = 1'b0;
        acc_ok = 1'b0;
        if (fr.spi_err) begin
            resp_d.kind = SPRE_RESP_SPI_ERR; // [RQ23]
        end else if (fr.miso_err) begin
            resp_d.kind = SPRE_RESP_MISO_ERR; // [RQ23]
        end else if (accel_mismatch) begin
            resp_d.kind = SPRE_RESP_INV_ACCEL; // [RQ1] [RQ2]
        end else if (reg_invalid) begin
            resp_d.kind = SPRE_RESP_INV_REG; // [RQ3] [RQ5]
        end else if (!fr.is_accel) begin
            resp_d.kind = fr.is_write ? SPRE_RESP_REG_WRITE : SPRE_RESP_REG_READ; // [RQ22]
        end else if (init_q) begin
            resp_d.kind = SPRE_RESP_INT_ERR; // [RQ6] [RQ9]
        end else if (resoc_q) begin
            resp_d.kind = SPRE_RESP_INV_ACCEL; // [RQ21] [RQ6] [RQ9]
        end else if (crc_err || lgc_q) begin
            resp_d.kind = SPRE_RESP_INT_ERR; // [RQ11]
        end else if (st_q) begin
            resp_d.kind = SPRE_RESP_ST_ERR; // [RQ14]
        end else begin
            acc_ok = 1'b1;
            arm_d = 1'b1; // [RQ16] [RQ19]
            if (offset_ovr_i[fr.axis] || ofs_tail_q[fr.axis] || modulator_ovr_i || sd_tail_q) begin
                resp_d.status = SPRE_STAT_OVR; // [RQ16] [RQ17] [RQ19]
            end
        end
    end

    // One extra status-10 answer once the over range has gone
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ofs_tail_q <= '0;
        end else begin
            for (int a = 0; a < SPRE_AXES; a++) begin
                if (offset_ovr_i[a]) begin
                    ofs_tail_q[a] <= 1'b1;
                end else if (new_frame && acc_ok && fr.axis == a[0]) begin
                    ofs_tail_q[a] <= 1'b0; // [RQ17]
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            sd_tail_q <= 1'b0;
        end else if (modulator_ovr_i) begin
            sd_tail_q <= 1'b1;
        end else if (new_frame && acc_ok) begin
            sd_tail_q <= 1'b0;
        end
    end

    // Response word back to the link, held until the next frame
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            resp_hold_q <= SPRE_RESP_RST;
            resp_tgl_q <= 1'b0;
        end else if (new_frame) begin
            resp_hold_q <= resp_d; // [RQ25]
            resp_tgl_q <= ~resp_tgl_q;
        end
    end

    // Side effects of each completed frame
    logic arm_q;
    logic wr_q;
    logic rd_q;
    logic sr_q;

    // Arming moves only on accepted acceleration data
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            arm_q <= 1'b0;
        end else begin
            arm_q <= new_frame & arm_d; // [RQ2] [RQ9] [RQ11] [RQ14]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            sr_q <= 1'b0;
        end else begin
            // Writes still land under an output mismatch
            wr_q <= reg_ok & fr.is_write; // [RQ22]
            rd_q <= reg_ok & ~fr.is_write & ~link_err; // [RQ22]
            sr_q <= stat_read; // [RQ8]
        end
    end

    assign arm_update_o = arm_q;
    assign reg_write_en_o = wr_q;
    assign reg_read_en_o = rd_q;
    assign status_read_o = sr_q;
    assign pcm_enable_o = ~(init_q | resoc_q); // [RQ9]
    assign init_in_progress_flag_o = init_q;
    assign reset_occurred_flag_o = resoc_q;
    assign internal_error_flag_o = int_err;
    assign offset_ovr_flag_o = ofs_q;
    assign modulator_overrange_flag_o = sd_q;

endmodule : spre_exception_handler

// File: verification/spre_props.sv
// Checker for the exception handler: core-domain flags, pulses and PCM enable.
// Assumes it is bound to spre_exception_handler; resetn_i is active low.
`timescale 1ns/100ps
module spre_props (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Fault sources
    input wire logic init_done_i,
    input wire logic otp_crc_err_i,
    // Flags and pulses
    input wire logic init_in_progress_flag_o,
    input wire logic reset_occurred_flag_o,
    input wire logic internal_error_flag_o,
    input wire logic [1:0] offset_ovr_flag_o,
    input wire logic modulator_overrange_flag_o,
    input wire logic arm_update_o,
    input wire logic pcm_enable_o,
    input wire logic reg_write_en_o,
    input wire logic reg_read_en_o,
    input wire logic status_read_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic any_pulse;
    assign any_pulse = arm_update_o || reg_write_en_o || reg_read_en_o;
    // Flags may only drop around a status read pulse
    sequence s_rd_near;
        status_read_o || $past(status_read_o);
    endsequence
    sequence s_init_gone;
        ##[1:3] !init_in_progress_flag_o;
    endsequence
    chk_pcm_off:
        assert property ((init_in_progress_flag_o || reset_occurred_flag_o) |-> !pcm_enable_o)
        else $error("pcm enabled during reset indication");
    chk_init_clear:
        assert property (init_in_progress_flag_o && init_done_i |-> s_init_gone)
        else $error("init flag did not clear");
    chk_rst_sticky:
        assert property ($fell(reset_occurred_flag_o) |-> s_rd_near)
        else $error("reset flag dropped without status read");
    chk_rst_cleared:
        assert property (status_read_o |-> ##[0:1] !reset_occurred_flag_o)
        else $error("status read left reset flag set");
    chk_ierr_sticky:
        assert property ($fell(internal_error_flag_o) |-> s_rd_near)
        else $error("internal error dropped without status read");
    chk_ovr_sticky:
        assert property (($fell(offset_ovr_flag_o[0]) || $fell(offset_ovr_flag_o[1])
            || $fell(modulator_overrange_flag_o)) |-> s_rd_near)
        else $error("over-range flag dropped without status read");
    chk_otp_perm:
        assert property (otp_crc_err_i |-> ##[1:3] internal_error_flag_o [*8])
        else $error("otp crc error not held");
    chk_arm_gated:
        assert property (arm_update_o |-> !(init_in_progress_flag_o || reset_occurred_flag_o
            || internal_error_flag_o))
        else $error("arming updated during error");
    chk_pulse_once:
        assert property (any_pulse |=> !any_pulse [*3])
        else $error("frame pulse repeated");
    chk_pulse_excl:
        assert property ($onehot0({arm_update_o, reg_write_en_o, reg_read_en_o}))
        else $error("two frame actions at once");
endmodule : spre_props

// File: verification/spre_host_model.sv
// Host-side model: hands the handler one frame summary per SPI frame.
// Assumes a free-running link clock; summaries mean nothing outside the strobe.
`timescale 1ns/100ps
module spre_host_model (
    // Link side
    input wire logic link_clk_i,
    output logic frame_done_o,
    output spre_pkg::spre_frame_t frame_o
);
    import spre_pkg::*;
    initial begin
        frame_done_o = 1'b0;
        frame_o = SPRE_FRAME_RST;
    end
    // A whole 16-clock frame collapses to one strobe; bad counts arrive as spi_err
    task automatic send(input spre_frame_t f);
        @(negedge link_clk_i);
        frame_done_o = 1'b1;
        frame_o = f;
        @(negedge link_clk_i);
        frame_done_o = 1'b0;
        frame_o = ~f; // Stale summary must not linger
    endtask : send
endmodule : spre_host_model

// File: verification/testbench.sv
// Bench for the exception handler: frames go in via the host model, answers are compared.
// Assumes the package and handler under core/; link clock unrelated to the core clock.
`timescale 1ns/100ps
module testbench;
    import spre_pkg::*;
    localparam logic [9:0] ACC0 = 10'h080, ACC1 = 10'h0a0, RDST = 10'h005, WROK = 10'h048;
    logic core_clk_i, resetn_i, link_clk_i, lock, init_done, otp, wcrc, st, lse, mod;
    logic frame_done, ini_f, rst_f, ierr_f, mod_f, arm, pcm, wr, rd, sr;
    logic [1:0] ofs, ofs_f;
    spre_frame_t frame;
    spre_resp_t resp;
    int fails = 0, checked = 0, cyc = 0;
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        #3.7;
        forever #7.5 link_clk_i = ~link_clk_i;
    end
    spre_exception_handler dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i), .link_resetn_i(resetn_i),
        .frame_done_i(frame_done), .frame_i(frame), .next_resp_o(resp), .config_lock_flag_i(lock),
        .init_done_i(init_done), .otp_crc_err_i(otp), .wreg_crc_err_i(wcrc), .self_test_err_i(st),
        .logic_state_err_i(lse), .offset_ovr_i(ofs), .modulator_ovr_i(mod), .init_in_progress_flag_o(ini_f),
        .reset_occurred_flag_o(rst_f), .internal_error_flag_o(ierr_f), .offset_ovr_flag_o(ofs_f),
        .modulator_overrange_flag_o(mod_f), .arm_update_o(arm), .pcm_enable_o(pcm),
        .reg_write_en_o(wr), .reg_read_en_o(rd), .status_read_o(sr)
    );
    spre_host_model host (.link_clk_i(link_clk_i), .frame_done_o(frame_done), .frame_o(frame));
    task automatic wrap_up;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : tick
    task automatic do_reset;
        resetn_i = 1'b0;
        tick(6);
        resetn_i = 1'b1;
        tick(2);
    endtask : do_reset
    // Gathers pulses past the answer latency; frames stay over 1.2 us apart
    task automatic xfer(input logic [9:0] f, input logic [3:0] k, input logic [1:0] s, input logic [2:0] p);
        logic [3:0] seen;
        seen = 4'h0;
        host.send(f);
        repeat (14) begin
            @(negedge core_clk_i);
            seen = seen | {arm, wr, rd, sr};
        end
        chk({6'h0, seen, resp}, {6'h0, p, p[0] & f[0], k, s});
    endtask : xfer
    task automatic fault(input logic [2:0] v);
        {st, lse, wcrc} = v;
        tick(2);
        {st, lse, wcrc} = 3'h0;
        tick(3);
    endtask : fault
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        {lock, init_done, otp, wcrc, st, lse, mod, ofs} = '0;
        do_reset();
        chk(16'({resp, ini_f, rst_f, pcm}), 16'({SPRE_RESP_RST, 3'b110}));
        xfer(ACC0, SPRE_RESP_INT_ERR, 2'h0, 3'h0);
        init_done = 1'b1;
        tick(1);
        init_done = 1'b0;
        tick(3);
        chk(16'({ini_f, rst_f, pcm}), 16'h2);
        xfer(ACC0, SPRE_RESP_INV_ACCEL, 2'h0, 3'h0);
        xfer(RDST, SPRE_RESP_REG_READ, 2'h0, 3'h1);
        chk(16'({rst_f, pcm}), 16'h1);
        xfer(10'h090, SPRE_RESP_INV_ACCEL, 2'h0, 3'h0);
        xfer(ACC0, SPRE_RESP_VALID_ACC, SPRE_STAT_NORMAL, 3'h4);
        lock = 1'b1;
        xfer(WROK, SPRE_RESP_INV_REG, 2'h0, 3'h0);
        xfer(10'h04a, SPRE_RESP_REG_WRITE, 2'h0, 3'h2);
        lock = 1'b0;
        xfer(10'h040, SPRE_RESP_INV_REG, 2'h0, 3'h0);
        xfer(10'h000, SPRE_RESP_INV_REG, 2'h0, 3'h0);
        xfer(WROK, SPRE_RESP_REG_WRITE, 2'h0, 3'h2);
        xfer(10'h380, SPRE_RESP_SPI_ERR, 2'h0, 3'h0);
        xfer(10'h190, SPRE_RESP_MISO_ERR, 2'h0, 3'h0);
        xfer(10'h148, SPRE_RESP_MISO_ERR, 2'h0, 3'h2);
        ofs = 2'h1;
        tick(3);
        xfer(ACC0, SPRE_RESP_VALID_ACC, SPRE_STAT_OVR, 3'h4);
        xfer(ACC1, SPRE_RESP_VALID_ACC, SPRE_STAT_NORMAL, 3'h4);
        ofs = 2'h0;
        mod = 1'b1;
        tick(3);
        xfer(ACC1, SPRE_RESP_VALID_ACC, SPRE_STAT_OVR, 3'h4);
        mod = 1'b0;
        tick(3);
        xfer(ACC0, SPRE_RESP_VALID_ACC, SPRE_STAT_OVR, 3'h4);
        xfer(ACC0, SPRE_RESP_VALID_ACC, SPRE_STAT_NORMAL, 3'h4);
        chk(16'({ofs_f, mod_f}), 16'h3);
        xfer(RDST, SPRE_RESP_REG_READ, 2'h0, 3'h1);
        chk(16'({ofs_f, mod_f}), 16'h0);
        for (int i = 0; i < 3; i++) begin
            fault(3'h4 >> i);
            xfer(ACC0, i == 0 ? SPRE_RESP_ST_ERR : SPRE_RESP_INT_ERR, 2'h0, 3'h0);
            chk(16'({ierr_f, pcm}), 16'h3);
            xfer(RDST, SPRE_RESP_REG_READ, 2'h0, 3'h1);
            chk(16'(ierr_f), 16'h0);
        end
        {st, wcrc} = 2'h3;
        xfer(ACC0, SPRE_RESP_INT_ERR, 2'h0, 3'h0);
        xfer(RDST, SPRE_RESP_REG_READ, 2'h0, 3'h1);
        chk(16'(ierr_f), 16'h1);
        {st, wcrc} = 2'h0;
        xfer(RDST, SPRE_RESP_REG_READ, 2'h0, 3'h1);
        chk(16'(ierr_f), 16'h0);
        lock = 1'b1;
        fault(3'h1);
        xfer(RDST, SPRE_RESP_REG_READ, 2'h0, 3'h1);
        chk(16'(ierr_f), 16'h1);
        do_reset();
        chk(16'({resp, ierr_f}), 16'({SPRE_RESP_RST, 1'b0}));
        lock = 1'b0;
        otp = 1'b1;
        init_done = 1'b1;
        tick(2);
        {otp, init_done} = 2'h0;
        xfer(RDST, SPRE_RESP_REG_READ, 2'h0, 3'h1);
        xfer(ACC0, SPRE_RESP_INT_ERR, 2'h0, 3'h0);
        chk(16'(ierr_f), 16'h1);
        wrap_up();
    end
endmodule : testbench
bind spre_exception_handler spre_props u_props (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .init_done_i(init_done_i), .otp_crc_err_i(otp_crc_err_i),
    .init_in_progress_flag_o(init_in_progress_flag_o), .reset_occurred_flag_o(reset_occurred_flag_o),
    .internal_error_flag_o(internal_error_flag_o), .offset_ovr_flag_o(offset_ovr_flag_o),
    .modulator_overrange_flag_o(modulator_overrange_flag_o), .arm_update_o(arm_update_o),
    .pcm_enable_o(pcm_enable_o), .reg_write_en_o(reg_write_en_o), .reg_read_en_o(reg_read_en_o),
    .status_read_o(status_read_o)
);
